// *** dct_consts.vh ***
// Constants for the DRAM command timing block
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH

`define DCT_ADDR_W            8
`define DCT_ADDR_CTRL         8'h40
`define DCT_ADDR_STATUS       8'h44
`define DCT_ADDR_TIMING_A     8'h48
`define DCT_ADDR_TIMING_B     8'h4C

`define DCT_TIMING_A_RST      31'h0000_0000
`define DCT_TIMING_B_RST      19'h0_0000
`define DCT_CTRL_RST          2'h0

`define DCT_RC_HI             21
`define DCT_RC_LO             16
`define DCT_RFC_HI            15
`define DCT_RFC_LO            8
`define DCT_RRD_HI            7
`define DCT_RRD_LO            4
`define DCT_REFI_HI           3
`define DCT_REFI_LO           0

`define DCT_W2RDR_HI          18
`define DCT_W2RDR_LO          16
`define DCT_R2W_HI            15
`define DCT_R2W_LO            12
`define DCT_W2R_HI            11
`define DCT_W2R_LO            8
`define DCT_R2R_HI            7
`define DCT_R2R_LO            4
`define DCT_W2W_HI            3
`define DCT_W2W_LO            0

`define DCT_GEAR_1_1          2'h0
`define DCT_GEAR_5_4          2'h1
`define DCT_GEAR_4_5          2'h2

`define DCT_SF_PKTS_STD       6'h2A
`define DCT_SF_PKTS_4_5       6'h28

`define DCT_CMD_ACT           2'h0
`define DCT_CMD_REF           2'h1
`define DCT_CMD_RD            2'h2
`define DCT_CMD_WR            2'h3

`endif

// *** dct_gap_cnt.v ***
// Loadable down-counter that reports a command gap still running
`timescale 1ns/100ps
module dct_gap_cnt #(
  parameter W = 4
) (
  input  wire         i_mclk,
  input  wire         i_sys_rst,
  input  wire         i_load,
  input  wire [W-1:0] i_val,
  output wire         o_busy
);

  reg  [W-1:0] cnt_r;
  reg  [W-1:0] cnt_nxt;

  // Loaded with N at issue; the next command may go N cycles later
  assign o_busy = (cnt_r > {{(W-1){1'b0}}, 1'b1});

  always @*
  begin
    cnt_nxt = cnt_r;
    if (i_load)
      cnt_nxt = i_val;
    else if (cnt_r != {W{1'b0}})
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cnt_r <= {W{1'b0}};
    else
      cnt_r <= cnt_nxt;
  end

endmodule

// *** dct_top.v ***
// DRAM command spacing and refresh scheduling with its register port
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "dct_consts.vh"
module dct_top #(
  parameter NUM_RANK = 8,
  parameter RANK_W   = 3,
  parameter RPD_W    = 1,
  parameter BANK_W   = 3
) (
  input  wire                   i_mclk,
  input  wire                   i_sys_rst,
  input  wire [`DCT_ADDR_W-1:0] i_reg_addr,
  input  wire [31:0]            i_reg_wdata,
  input  wire                   i_reg_wr,
  input  wire                   i_reg_rd,
  output wire [31:0]            o_reg_rdata,
  input  wire                   i_link_pkt,
  input  wire                   i_cmd_valid,
  input  wire [1:0]             i_cmd_type,
  input  wire [RANK_W-1:0]      i_cmd_rank,
  input  wire [BANK_W-1:0]      i_cmd_bank,
  output wire                   o_cmd_ack,
  output wire                   o_cmd_issue,
  output wire [1:0]             o_cmd_type,
  output wire [RANK_W-1:0]      o_cmd_rank,
  output wire [BANK_W-1:0]      o_cmd_bank,
  output wire                   o_ref_pending
);

  localparam NUM_BANK = 1 << BANK_W;
  localparam NUM_DIMM = NUM_RANK >> RPD_W;
  localparam DIMM_W   = RANK_W - RPD_W;
  localparam NUM_ROW  = NUM_RANK * NUM_BANK;
  reg  [30:0]              timing_a_r;
  reg  [18:0]              timing_b_r;
  reg  [1:0]               gear_r;
  reg  [31:0]              rdata_r;
  reg  [31:0]              rdata_nxt;
  reg  [5:0]               pkt_cnt_r;
  reg  [3:0]               sf_cnt_r;
  reg                      ref_pend_r;
  reg  [RANK_W-1:0]        ref_ptr_r;
  reg                      ack_r;
  reg                      issue_r;
  reg  [1:0]               type_r;
  reg  [RANK_W-1:0]        rank_r;
  reg  [BANK_W-1:0]        bank_r;
  reg  [BANK_W-1:0]        last_act_bank_r [0:NUM_RANK-1];
  reg  [RANK_W-1:0]        last_wr_rank_r  [0:NUM_DIMM-1];
  reg  [RANK_W-1:0]        last_rd_rank_r  [0:NUM_DIMM-1];
  wire [NUM_ROW-1:0]       row_busy;
  wire [NUM_RANK-1:0]      rank_rows_busy;
  wire [NUM_RANK-1:0]      rrd_busy;
  wire [NUM_RANK-1:0]      w2r_busy;
  wire [NUM_DIMM-1:0]      r2w_busy;
  wire [NUM_DIMM-1:0]      w2w_busy;
  wire [NUM_DIMM-1:0]      w2rdr_busy;
  wire [NUM_DIMM-1:0]      r2r_busy;
  wire                     rfc_busy;
  wire [3:0]               refi;
  wire                     ref_off;
  wire [5:0]               sf_pkts;
  wire                     sf_end;
  wire                     slot_tick;
  wire [DIMM_W-1:0]        cand_dimm;
  wire [DIMM_W-1:0]        iss_dimm;
  reg                      cmd_ok;
  reg                      ref_ok;
  wire                     go_ref;
  wire                     go_cmd;
  wire                     iss;
  wire [1:0]               iss_type;
  wire [RANK_W-1:0]        iss_rank;
  wire [BANK_W-1:0]        iss_bank;
  wire                     iss_act;
  wire                     iss_ref;
  wire                     iss_rd;
  wire                     iss_wr;
  integer                  k;
  assign o_reg_rdata   = rdata_r;
  assign o_cmd_ack     = ack_r;
  assign o_cmd_issue   = issue_r;
  assign o_cmd_type    = type_r;
  assign o_cmd_rank    = rank_r;
  assign o_cmd_bank    = bank_r;
  assign o_ref_pending = ref_pend_r;

  // Register port: writes take effect at the strobe edge
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      timing_a_r <= `DCT_TIMING_A_RST;
      timing_b_r <= `DCT_TIMING_B_RST;
      gear_r     <= `DCT_CTRL_RST;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `DCT_ADDR_TIMING_A: timing_a_r <= i_reg_wdata[30:0];
        `DCT_ADDR_TIMING_B: timing_b_r <= i_reg_wdata[18:0];
        `DCT_ADDR_CTRL:     gear_r     <= i_reg_wdata[1:0];
        default:            gear_r     <= gear_r;
      endcase
    end
  end

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `DCT_ADDR_TIMING_A: rdata_nxt = {1'b0, timing_a_r};
        `DCT_ADDR_TIMING_B: rdata_nxt = {13'h0000, timing_b_r};
        `DCT_ADDR_CTRL:     rdata_nxt = {30'h0000_0000, gear_r};
        `DCT_ADDR_STATUS:   rdata_nxt = {4'h0, pkt_cnt_r, 2'h0, sf_cnt_r,
                                         {(8-RANK_W){1'b0}}, ref_ptr_r,
                                         7'h00, ref_pend_r};
        default:            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  // Refresh slot timer counts link packets, then superframes
  assign refi      = timing_a_r[`DCT_REFI_HI:`DCT_REFI_LO];
  assign ref_off   = (refi == 4'h0);
  assign sf_pkts   = (gear_r == `DCT_GEAR_4_5) ? `DCT_SF_PKTS_4_5 : `DCT_SF_PKTS_STD;
  // Ranks are served in turn, so each rank sees one slot in every eight
  assign sf_end    = i_link_pkt & (pkt_cnt_r >= sf_pkts - 6'h01);
  assign slot_tick = ~ref_off & sf_end & (sf_cnt_r >= refi - 4'h1);

  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pkt_cnt_r  <= 6'h00;
      sf_cnt_r   <= 4'h0;
      ref_pend_r <= 1'b0;
      ref_ptr_r  <= {RANK_W{1'b0}};
    end
    else if (ref_off)
    begin
      pkt_cnt_r  <= 6'h00;
      sf_cnt_r   <= 4'h0;
      ref_pend_r <= 1'b0;
      ref_ptr_r  <= {RANK_W{1'b0}};
    end
    else
    begin
      if (sf_end)
        pkt_cnt_r <= 6'h00;
      else if (i_link_pkt)
        pkt_cnt_r <= pkt_cnt_r + 6'h01;
      if (slot_tick)
        sf_cnt_r <= 4'h0;
      else if (sf_end)
        sf_cnt_r <= sf_cnt_r + 4'h1;
      // A new slot wins over the clear by the refresh being issued
      ref_pend_r <= slot_tick | (ref_pend_r & ~go_ref);
      if (go_ref)
        ref_ptr_r <= ref_ptr_r + {{(RANK_W-1){1'b0}}, 1'b1};
    end
  end

  assign cand_dimm = i_cmd_rank[RANK_W-1:RPD_W];
  // Legality checks against the running gap counters
  always @*
  begin
    ref_ok = ~rank_rows_busy[ref_ptr_r] & ~rfc_busy & ~rrd_busy[ref_ptr_r];
    cmd_ok = 1'b0;
    case (i_cmd_type)
      `DCT_CMD_ACT:
        cmd_ok = ~row_busy[{i_cmd_rank, i_cmd_bank}] & ~rfc_busy &
                 ~(rrd_busy[i_cmd_rank] &
                   (last_act_bank_r[i_cmd_rank] != i_cmd_bank));
      `DCT_CMD_REF:
        cmd_ok = ~rank_rows_busy[i_cmd_rank] & ~rfc_busy & ~rrd_busy[i_cmd_rank];
      `DCT_CMD_RD:
        cmd_ok = ~w2r_busy[i_cmd_rank] &
                 ~(w2rdr_busy[cand_dimm] &
                   (last_wr_rank_r[cand_dimm] != i_cmd_rank)) &
                 ~(r2r_busy[cand_dimm] &
                   (last_rd_rank_r[cand_dimm] != i_cmd_rank));
      `DCT_CMD_WR:
        cmd_ok = ~r2w_busy[cand_dimm] & ~w2w_busy[cand_dimm];
      default:
        cmd_ok = 1'b0;
    endcase
  end

  // Refresh due takes priority; the ack gap keeps a held candidate from going twice
  // A slot pending when software zeroes the interval must not still go out
  assign go_ref   = ref_pend_r & ~ref_off & ref_ok;
  assign go_cmd   = i_cmd_valid & ~ref_pend_r & ~ack_r & cmd_ok;
  assign iss      = go_ref | go_cmd;
  assign iss_type = go_ref ? `DCT_CMD_REF : i_cmd_type;
  assign iss_rank = go_ref ? ref_ptr_r : i_cmd_rank;
  assign iss_bank = go_ref ? {BANK_W{1'b0}} : i_cmd_bank;
  assign iss_dimm = iss_rank[RANK_W-1:RPD_W];
  assign iss_act  = iss & (iss_type == `DCT_CMD_ACT);
  assign iss_ref  = iss & (iss_type == `DCT_CMD_REF);
  assign iss_rd   = iss & (iss_type == `DCT_CMD_RD);
  assign iss_wr   = iss & (iss_type == `DCT_CMD_WR);

  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ack_r   <= 1'b0;
      issue_r <= 1'b0;
      type_r  <= 2'h0;
      rank_r  <= {RANK_W{1'b0}};
      bank_r  <= {BANK_W{1'b0}};
    end
    else
    begin
      ack_r   <= go_cmd;
      issue_r <= iss;
      type_r  <= iss_type;
      rank_r  <= iss_rank;
      bank_r  <= iss_bank;
    end
  end

  // History needed by the different-bank and different-rank checks
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (k = 0; k < NUM_RANK; k = k + 1)
        last_act_bank_r[k] <= {BANK_W{1'b0}};
      for (k = 0; k < NUM_DIMM; k = k + 1)
      begin
        last_wr_rank_r[k] <= {RANK_W{1'b0}};
        last_rd_rank_r[k] <= {RANK_W{1'b0}};
      end
    end
    else
    begin
      if (iss_act)
        last_act_bank_r[iss_rank] <= iss_bank;
      if (iss_wr)
        last_wr_rank_r[iss_dimm] <= iss_rank;
      if (iss_rd)
        last_rd_rank_r[iss_dimm] <= iss_rank;
    end
  end

  // Refresh recovery is shared by the whole branch
  dct_gap_cnt #(.W(8)) u_rfc (
    .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
    .i_load    (iss_ref),
    .i_val     (timing_a_r[`DCT_RFC_HI:`DCT_RFC_LO]),
    .o_busy    (rfc_busy)
  );
  genvar g;
  generate
    for (g = 0; g < NUM_ROW; g = g + 1)
    begin : g_bank
      dct_gap_cnt #(.W(6)) u_rc (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_act & ({iss_rank, iss_bank} == g)),
        .i_val     (timing_a_r[`DCT_RC_HI:`DCT_RC_LO]),
        .o_busy    (row_busy[g])
      );
    end
    for (g = 0; g < NUM_RANK; g = g + 1)
    begin : g_rank
      assign rank_rows_busy[g] = |row_busy[g*NUM_BANK +: NUM_BANK];
      dct_gap_cnt #(.W(4)) u_rrd (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_act & (iss_rank == g)),
        .i_val     (timing_a_r[`DCT_RRD_HI:`DCT_RRD_LO]),
        .o_busy    (rrd_busy[g])
      );
      dct_gap_cnt #(.W(4)) u_w2r (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_wr & (iss_rank == g)),
        .i_val     (timing_b_r[`DCT_W2R_HI:`DCT_W2R_LO]),
        .o_busy    (w2r_busy[g])
      );
    end
    for (g = 0; g < NUM_DIMM; g = g + 1)
    begin : g_dimm
      dct_gap_cnt #(.W(4)) u_r2w (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_rd & (iss_dimm == g)),
        .i_val     (timing_b_r[`DCT_R2W_HI:`DCT_R2W_LO]),
        .o_busy    (r2w_busy[g])
      );
      dct_gap_cnt #(.W(4)) u_r2r (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_rd & (iss_dimm == g)),
        .i_val     (timing_b_r[`DCT_R2R_HI:`DCT_R2R_LO]),
        .o_busy    (r2r_busy[g])
      );
      dct_gap_cnt #(.W(4)) u_w2w (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_wr & (iss_dimm == g)),
        .i_val     (timing_b_r[`DCT_W2W_HI:`DCT_W2W_LO]),
        .o_busy    (w2w_busy[g])
      );
      dct_gap_cnt #(.W(3)) u_w2rdr (
        .i_mclk    (i_mclk), .i_sys_rst (i_sys_rst),
        .i_load    (iss_wr & (iss_dimm == g)),
        .i_val     (timing_b_r[`DCT_W2RDR_HI:`DCT_W2RDR_LO]),
        .o_busy    (w2rdr_busy[g])
      );
    end
  endgenerate

endmodule

// *** dct_top_monitor.sv ***
// Checker for the command handshake and internal refresh issue of dct_top
`timescale 1ns/100ps
`include "dct_consts.vh"
module dct_top_monitor #(
  parameter RANK_W = 3,
  parameter BANK_W = 3
) (
  input wire              i_mclk,
  input wire              i_sys_rst,
  input wire              i_reg_rd,
  input wire [31:0]       o_reg_rdata,
  input wire              i_cmd_valid,
  input wire [1:0]        i_cmd_type,
  input wire [RANK_W-1:0] i_cmd_rank,
  input wire [BANK_W-1:0] i_cmd_bank,
  input wire              o_cmd_ack,
  input wire              o_cmd_issue,
  input wire [1:0]        o_cmd_type,
  input wire [RANK_W-1:0] o_cmd_rank,
  input wire [BANK_W-1:0] o_cmd_bank,
  input wire              o_ref_pending
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Issue without ack can only be the internal refresh
  sequence s_int_ref;
    o_cmd_issue && !o_cmd_ack;
  endsequence
  a_ack_single_pulse: assert property (o_cmd_ack |=> !o_cmd_ack)
    else $error("ack in two cycles running");
  a_ack_with_issue: assert property (o_cmd_ack |-> o_cmd_issue)
    else $error("ack without issue");
  a_ack_needs_valid: assert property (o_cmd_ack |-> $past(i_cmd_valid))
    else $error("ack without candidate");
  a_ref_beats_cmd: assert property (o_cmd_ack |-> !$past(o_ref_pending))
    else $error("candidate taken over pending refresh");
  a_ack_echo_cmd: assert property (o_cmd_ack |-> o_cmd_type == $past(i_cmd_type)
    && o_cmd_rank == $past(i_cmd_rank) && o_cmd_bank == $past(i_cmd_bank))
    else $error("issued command differs from candidate");
  a_ref_from_pending: assert property (s_int_ref |-> $past(o_ref_pending))
    else $error("internal issue without pending refresh");
  a_ref_kind_bank: assert property (s_int_ref |-> o_cmd_type == `DCT_CMD_REF
    && o_cmd_bank == 3'h0)
    else $error("internal issue not a refresh");
  a_rdata_one_shot: assert property (o_reg_rdata != 32'h0 |-> $past(i_reg_rd))
    else $error("read data outside its cycle");
endmodule

bind dct_top dct_top_monitor #(.RANK_W(RANK_W), .BANK_W(BANK_W)) u_mon (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_cmd_valid(i_cmd_valid), .i_cmd_type(i_cmd_type), .i_cmd_rank(i_cmd_rank),
  .i_cmd_bank(i_cmd_bank), .o_cmd_ack(o_cmd_ack), .o_cmd_issue(o_cmd_issue),
  .o_cmd_type(o_cmd_type), .o_cmd_rank(o_cmd_rank), .o_cmd_bank(o_cmd_bank),
  .o_ref_pending(o_ref_pending));

// *** dct_dimm_model.sv ***
// Far-side model: link packet pacing and a log of the internal (unacked) refreshes reaching the ranks
`timescale 1ns/100ps
module dct_dimm_model (
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  input  wire       i_issue,
  input  wire       i_ack,
  input  wire [1:0] i_type,
  input  wire [2:0] i_rank,
  output reg        o_link_pkt
);
  integer cyc_r, ref_cnt, last_t, prev_t, last_rank, prev_rank;
  // One packet every other core cycle; a coarse stand-in for the link rate
  always @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_link_pkt <= 1'b0;
      cyc_r <= 0;
      ref_cnt <= 0;
      last_t <= 0;
      prev_t <= 0;
      last_rank <= 0;
      prev_rank <= 0;
    end
    else
    begin
      o_link_pkt <= ~o_link_pkt;
      cyc_r <= cyc_r + 1;
      if (i_issue && !i_ack && i_type == 2'h1)
      begin
        ref_cnt <= ref_cnt + 1;
        prev_t <= last_t;
        last_t <= cyc_r;
        prev_rank <= last_rank;
        last_rank <= i_rank;
      end
    end
  end
endmodule

// *** dct_top_test.sv ***
// Self-checking bench for the DRAM command timing block
`timescale 1ns/100ps
`include "dct_consts.vh"
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module dct_top_test;
  reg         i_mclk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [7:0]  i_reg_addr = 8'h00;
  reg  [31:0] i_reg_wdata = 32'h0;
  reg         i_reg_wr = 1'b0;
  reg         i_reg_rd = 1'b0;
  reg         i_cmd_valid = 1'b0;
  reg  [1:0]  i_cmd_type = 2'h0;
  reg  [2:0]  i_cmd_rank = 3'h0;
  reg  [2:0]  i_cmd_bank = 3'h0;
  wire [31:0] o_reg_rdata;
  wire        link_pkt;
  wire        o_cmd_ack;
  wire        o_cmd_issue;
  wire [1:0]  o_cmd_type;
  wire [2:0]  o_cmd_rank;
  wire [2:0]  o_cmd_bank;
  wire        o_ref_pending;
  int         miscompares = 0;
  int         compares = 0;
  int         ta;
  int         tb;
  int         c0;
  // Pairs: first cmd, second cmd, expected decision spacing
  int g[11][7] = '{'{0,0,0,0,0,0,20}, '{0,0,1,0,0,2,7}, '{1,2,0,0,4,0,12},
    '{1,2,0,1,5,0,12}, '{3,0,0,2,1,0,5}, '{2,2,0,3,3,0,6}, '{3,4,0,2,4,0,9},
    '{2,6,0,2,7,0,4}, '{3,0,0,3,1,0,8}, '{0,0,0,0,2,0,3}, '{2,0,0,2,2,0,3}};

  always #2 i_mclk = ~i_mclk;

  dct_top uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_link_pkt(link_pkt), .i_cmd_valid(i_cmd_valid),
    .i_cmd_type(i_cmd_type), .i_cmd_rank(i_cmd_rank), .i_cmd_bank(i_cmd_bank),
    .o_cmd_ack(o_cmd_ack), .o_cmd_issue(o_cmd_issue), .o_cmd_type(o_cmd_type),
    .o_cmd_rank(o_cmd_rank), .o_cmd_bank(o_cmd_bank), .o_ref_pending(o_ref_pending));

  dct_dimm_model m (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_issue(o_cmd_issue),
    .i_ack(o_cmd_ack), .i_type(o_cmd_type), .i_rank(o_cmd_rank), .o_link_pkt(link_pkt));

  task print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task rd(input [7:0] a, input [31:0] e);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(posedge i_mclk);
    `CHK(o_reg_rdata, e, "read data")
    @(posedge i_mclk);
    `CHK(o_reg_rdata, 32'h0, "read data after its cycle")
  endtask

  // Holds the candidate until ack; returns the cycle the ack was seen
  task cmd(input [1:0] t, input [2:0] r, input [2:0] b, output int at);
    int n;
    i_cmd_type <= t;
    i_cmd_rank <= r;
    i_cmd_bank <= b;
    i_cmd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (o_cmd_ack !== 1'b1 && n < 200);
    i_cmd_valid <= 1'b0;
    at = m.cyc_r;
    if (n >= 200)
    begin
      miscompares++;
      print_verdict;
    end
    @(posedge i_mclk);
  endtask

  task wait_refs(input int k);
    int n;
    c0 = m.ref_cnt;
    for (n = 0; n < 4000 && m.ref_cnt < c0 + k; n++)
      @(posedge i_mclk);
    if (n >= 4000)
    begin
      miscompares++;
      print_verdict;
    end
  endtask

  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(`DCT_ADDR_TIMING_A, 32'h0);
    rd(`DCT_ADDR_TIMING_B, 32'h0);
    wr(`DCT_ADDR_STATUS, 32'hFFFFFFFF);
    rd(`DCT_ADDR_STATUS, 32'h0);
    wr(`DCT_ADDR_TIMING_A, 32'hFFFFFFF0);
    rd(`DCT_ADDR_TIMING_A, 32'h7FFFFFF0);
    wr(`DCT_ADDR_TIMING_B, 32'hFFFFFFFF);
    rd(`DCT_ADDR_TIMING_B, 32'h0007FFFF);
    wr(8'h50, 32'hFFFFFFFF);
    rd(8'h50, 32'h0);
    wr(`DCT_ADDR_CTRL, 32'h3);
    rd(`DCT_ADDR_CTRL, 32'h3);
    $display("test registers done");
    wr(`DCT_ADDR_TIMING_A, 32'h00140C70);
    wr(`DCT_ADDR_TIMING_B, 32'h00056948);
    for (int i = 0; i < 11; i++)
    begin
      repeat (40) @(posedge i_mclk);
      cmd(g[i][0][1:0], g[i][1][2:0], g[i][2][2:0], ta);
      cmd(g[i][3][1:0], g[i][4][2:0], g[i][5][2:0], tb);
      `CHK(tb - ta, g[i][6], "command spacing")
    end
    $display("test command gaps done");
    wr(`DCT_ADDR_CTRL, {30'h0, `DCT_GEAR_1_1});
    wr(`DCT_ADDR_TIMING_A, 32'h00140C76);
    wait_refs(3);
    `CHK(m.last_t - m.prev_t, 6 * 42 * 8 * 2 / 8, "refresh period 1:1")
    `CHK(m.last_rank, (m.prev_rank + 1) % 8, "refresh rank order")
    wr(`DCT_ADDR_CTRL, {30'h0, `DCT_GEAR_5_4});
    wait_refs(2);
    `CHK(m.last_t - m.prev_t, 6 * 42 * 2, "refresh period 5:4")
    wr(`DCT_ADDR_CTRL, {30'h0, `DCT_GEAR_4_5});
    wr(`DCT_ADDR_TIMING_A, 32'h00140C78);
    wait_refs(3);
    `CHK(m.last_t - m.prev_t, 8 * 40 * 2, "refresh period 4:5")
    cmd(`DCT_CMD_RD, 3'h1, 3'h0, ta);
    $display("test refresh timing done");
    wr(`DCT_ADDR_TIMING_A, 32'h00140C70);
    // A refresh decided at the write edge is logged one edge later
    @(posedge i_mclk);
    c0 = m.ref_cnt;
    repeat (1500) @(posedge i_mclk);
    `CHK(m.ref_cnt, c0, "refresh after disable")
    `CHK(o_ref_pending, 1'b0, "pending after disable")
    rd(`DCT_ADDR_STATUS, 32'h0);
    $display("test refresh disable done");
    print_verdict;
  end
endmodule
